//--- hw/cio_buf2.sv
`timescale 1ns/1ps

// two-entry buffer; full only when both entries hold words
module cio_buf2 #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 2
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic sys_rst_i,
  // fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [$clog2(DEPTH)-1:0] wr_r;
  logic [$clog2(DEPTH)-1:0] rd_r;
  logic [$clog2(DEPTH):0] cnt_r;
  wire push = in_valid_i && in_ready_o;
  wire pop = out_valid_o && out_ready_i;

  // honest full and empty from the occupancy count
  assign in_ready_o = (cnt_r != DEPTH[$clog2(DEPTH):0]);
  assign out_valid_o = (cnt_r != '0);
  assign out_data_o = mem_r[rd_r];

  // storage is not reset, so it maps to plain registers
  always_ff @(posedge clock_i)
  begin
    if (push)
      mem_r[wr_r] <= in_data_i;
  end

  // pointers and count
  always_ff @(posedge clock_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      wr_r <= '0;
      rd_r <= '0;
      cnt_r <= '0;
    end
    else
    begin
      if (push)
        wr_r <= wr_r + 1'b1;
      if (pop)
        rd_r <= rd_r + 1'b1;
      if (push && !pop)
        cnt_r <= cnt_r + 1'b1;
      else if (pop && !push)
        cnt_r <= cnt_r - 1'b1;
    end
  end

endmodule

//--- hw/cio_port.sv
`timescale 1ns/1ps

// How it works
// - active-low frame strobe opens a frame; capture bits on next 16 falling clocks
// - sample serial input into the input shift register on each of those falling clocks
// - once the frame is open, change serial output only on rising serial clock edges
// - frame strobe fall puts pending word's msb on output before any clock
// - clock may idle high or low; shift out only after a falling edge
// - results, readback and temperature leave on the single serial output
// - each pin independently acts as dac, adc, digital in or digital out
// - eighth pin may show conversion busy instead of its normal role
module cio_port (
  // system clock and reset
  input wire logic clock_i,
  input wire logic sys_rst_i,
  // serial link, clocked by the host
  input wire logic sclk_i,
  input wire logic sync_n_i,
  input wire logic sdi_i,
  output logic sdo_o,
  // received words toward the register logic
  output logic rx_valid_o,
  input wire logic rx_ready_i,
  output cio_pkg::cio_word_t rx_word_o,
  // word to return on the next frame
  input wire logic tx_load_i,
  input wire cio_pkg::cio_word_t tx_word_i,
  // pin roles and busy option
  input wire logic [15:0] pin_role_i,
  input wire logic busy_en_i,
  input wire logic conv_busy_i,
  output cio_pkg::cio_pin_sel_t pin_sel_o,
  output logic busy_pin_o,
  output logic rx_overrun_o
);

  // ---------------------------------------------------------------
  // link domain: input shifting on the serial clock
  // ---------------------------------------------------------------
  logic [15:0] rx_sh_r;
  logic [4:0] rx_cnt_r;
  logic rx_tgl_r;
  logic [15:0] rx_hold_r;
  wire frame_rst = sys_rst_i || sync_n_i;

  // frame strobe high clears the count, so a short frame never completes
  always_ff @(negedge sclk_i or posedge frame_rst)
  begin
    if (frame_rst)
      rx_cnt_r <= '0;
    else if (rx_cnt_r != cio_pkg::FRAME_BITS)
      rx_cnt_r <= rx_cnt_r + 5'h01;
  end

  // msb first sampling on falling edges; the word is handed over by toggle
  always_ff @(negedge sclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      rx_sh_r <= cio_pkg::WORD_RST;
      rx_hold_r <= cio_pkg::WORD_RST;
      rx_tgl_r <= 1'b0;
    end
    else if (!sync_n_i && rx_cnt_r != cio_pkg::FRAME_BITS)
    begin
      rx_sh_r <= {rx_sh_r[14:0], sdi_i};
      if (rx_cnt_r == cio_pkg::FRAME_BITS - 5'h01)
      begin
        rx_hold_r <= {rx_sh_r[14:0], sdi_i};
        rx_tgl_r <= ~rx_tgl_r;
      end
    end
  end

  // ---------------------------------------------------------------
  // link domain: output shifting
  // ---------------------------------------------------------------
  logic fell_r;
  logic [15:0] tx_cap_r;

  // falling edge seen in this frame arms the next rising shift
  always_ff @(negedge sclk_i or posedge frame_rst)
  begin
    if (frame_rst)
      fell_r <= 1'b0;
    else
      fell_r <= 1'b1;
  end

  // serial clock may stand still, so the shifter counts shifts instead
  // of reloading; the output mux picks the bit of the latched word
  logic [3:0] tx_idx_r;
  always_ff @(posedge sclk_i or posedge frame_rst)
  begin
    if (frame_rst)
      tx_idx_r <= 4'h0;
    else if (fell_r && tx_idx_r != 4'hf)
      tx_idx_r <= tx_idx_r + 4'h1;
  end

  wire [3:0] tx_bit = 4'hf - tx_idx_r;
  assign sdo_o = sync_n_i ? 1'b0 : tx_cap_r[tx_bit];

  // ---------------------------------------------------------------
  // system domain: word handover and the returned word
  // ---------------------------------------------------------------
  logic [2:0] tgl_sync_r;
  logic tgl_seen_r;
  logic [2:0] sync_s_r;
  logic in_frame_r;
  logic buf_ready;

  // three flops on the toggle; a change counts once stages two and three agree
  always_ff @(posedge clock_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      tgl_sync_r <= 3'b000;
      tgl_seen_r <= 1'b0;
      sync_s_r <= 3'b111;
      in_frame_r <= 1'b0;
    end
    else
    begin
      tgl_sync_r <= {tgl_sync_r[1:0], rx_tgl_r};
      sync_s_r <= {sync_s_r[1:0], sync_n_i};
      if (tgl_sync_r[2] == tgl_sync_r[1])
        tgl_seen_r <= tgl_sync_r[2];
      if (sync_s_r[2] == sync_s_r[1])
        in_frame_r <= ~sync_s_r[2];
    end
  end

  // hold word is stable for a whole frame after the toggle, so it is safe
  wire word_evt = (tgl_sync_r[2] == tgl_sync_r[1]) && (tgl_sync_r[2] != tgl_seen_r);

  cio_buf2 #(
    .WIDTH(cio_pkg::WORD_BITS),
    .DEPTH(2)
  ) u_buf (
    .clock_i(clock_i),
    .sys_rst_i(sys_rst_i),
    .in_valid_i(word_evt),
    .in_ready_o(buf_ready),
    .in_data_i(rx_hold_r),
    .out_valid_o(rx_valid_o),
    .out_ready_i(rx_ready_i),
    .out_data_o(rx_word_o)
  );

  // a word arriving on a full buffer is dropped and flagged sticky
  always_ff @(posedge clock_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      rx_overrun_o <= 1'b0;
    else if (word_evt && !buf_ready)
      rx_overrun_o <= 1'b1;
  end

  // pending return word; loads are refused while a frame is open so the
  // link side sees a stable value, which the strobe fall then exposes
  logic [15:0] tx_pend_r;
  always_ff @(posedge clock_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      tx_pend_r <= cio_pkg::WORD_RST;
    else if (tx_load_i && !in_frame_r && sync_s_r[2])
      tx_pend_r <= tx_word_i;
  end

  // capture into the link side on the strobe's falling edge
  always_ff @(negedge sync_n_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      tx_cap_r <= cio_pkg::WORD_RST;
    else
      tx_cap_r <= tx_pend_r;
  end

  // ---------------------------------------------------------------
  // pin role decode
  // ---------------------------------------------------------------
  function automatic logic is_role(input logic [1:0] f, input cio_pkg::cio_role_t r);
    is_role = (f == r);
  endfunction

  logic [2:0] busy_s_r;
  logic busy_r;
  // busy comes from the converter's own timing: three flops, and the pin
  // follows only once stages two and three agree, so a runt never shows
  always_ff @(posedge clock_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      busy_s_r <= 3'b000;
      busy_r <= 1'b0;
    end
    else
    begin
      busy_s_r <= {busy_s_r[1:0], conv_busy_i & busy_en_i};
      if (busy_s_r[2] == busy_s_r[1])
        busy_r <= busy_s_r[2];
    end
  end

  genvar g;
  generate
    for (g = 0; g < cio_pkg::NUM_PINS; g++)
    begin : g_pin
      // busy option takes the eighth pin away from its normal role
      wire stolen = busy_en_i && (g == cio_pkg::BUSY_PIN);
      wire [1:0] role = pin_role_i[2*g +: 2];
      assign pin_sel_o.is_dac[g] = !stolen && is_role(role, cio_pkg::CIO_ROLE_DAC);
      assign pin_sel_o.is_adc[g] = !stolen && is_role(role, cio_pkg::CIO_ROLE_ADC);
      assign pin_sel_o.is_din[g] = !stolen && is_role(role, cio_pkg::CIO_ROLE_DIN);
      assign pin_sel_o.is_dout[g] = !stolen && is_role(role, cio_pkg::CIO_ROLE_DOUT);
    end
  endgenerate

  assign busy_pin_o = busy_r;

endmodule

//--- inc/cio_pkg.sv
package cio_pkg;

  // ---------------------------------------------------------------
  // frame and word geometry
  // ---------------------------------------------------------------
  localparam int WORD_BITS = 16;
  localparam int NUM_PINS = 8;
  localparam int CNT_BITS = 5;
  localparam logic [4:0] FRAME_BITS = 5'h10;
  localparam logic [15:0] WORD_RST = 16'h0000;
  localparam logic [2:0] BUSY_PIN = 3'h7;

  // ---------------------------------------------------------------
  // host clock limits, for reference by the bench
  // ---------------------------------------------------------------
  localparam int SCLK_WR_MAX_MHZ = 50;
  localparam int SCLK_RD_MAX_MHZ = 20;

  // ---------------------------------------------------------------
  // per-pin role and the carriers
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    CIO_ROLE_DAC = 2'b00,
    CIO_ROLE_ADC = 2'b01,
    CIO_ROLE_DIN = 2'b10,
    CIO_ROLE_DOUT = 2'b11
  } cio_role_t;

  localparam logic [1:0] ROLE_RST = 2'b10;

  typedef struct packed {
    logic [15:0] data;
  } cio_word_t;

  typedef struct packed {
    logic [7:0] is_dac;
    logic [7:0] is_adc;
    logic [7:0] is_din;
    logic [7:0] is_dout;
  } cio_pin_sel_t;

endpackage

//--- tb/cio_host_model.sv
`timescale 1ns/1ps

// host of the link; its clock stands still between frames
module cio_host_model (
  // link toward the device
  output logic sclk_o,
  output logic sync_n_o,
  output logic sdi_o,
  input wire logic sdo_i
);
  // idle link
  initial
  begin
    sclk_o = 1'b0;
    sync_n_o = 1'b1;
    sdi_o = 1'b0;
  end
  // one frame of n bits; 125 ns keeps well under the read limit
  task automatic xfer(input logic [15:0] tx, input int n, input logic idle,
                      output logic [15:0] rx);
    rx = 16'h0000;
    sclk_o = idle;
    #100 sync_n_o = 1'b0;
    for (int i = 0; i < n; i++)
    begin
      #31 sdi_o = tx[15-i];
      #31.5 sclk_o = 1'b1;
      #62.5 rx[15-i] = sdo_i;
      sclk_o = 1'b0;
    end
    #62.5 sclk_o = idle;
    #20 sync_n_o = 1'b1;
    sdi_o = ~sdi_o; // released line shows no stale bit
  endtask
endmodule

//--- tb/cio_port_monitor.sv
`timescale 1ns/1ps

// pin-level checker of the serial port
module cio_port_monitor (
  // clock and reset
  input wire logic clock_i,
  input wire logic sys_rst_i,
  // serial link
  input wire logic sclk_i,
  input wire logic sync_n_i,
  input wire logic sdo_o,
  // word side
  input wire logic rx_valid_o,
  input wire logic rx_ready_i,
  input wire cio_pkg::cio_word_t rx_word_o,
  input wire logic tx_load_i,
  input wire cio_pkg::cio_word_t tx_word_i,
  input wire logic rx_overrun_o,
  // busy pin
  input wire logic busy_en_i,
  input wire logic conv_busy_i,
  input wire logic busy_pin_o
);
  logic [15:0] pend_r;
  // shadow of the return word; a load inside a frame is ignored
  always_ff @(posedge clock_i or posedge sys_rst_i)
    if (sys_rst_i)
      pend_r <= 16'h0000;
    else if (tx_load_i && sync_n_i)
      pend_r <= tx_word_i.data;
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (sys_rst_i);
  // frame start, a held word and a quiet open frame
  sequence frame_fall;
    $fell(sync_n_i);
  endsequence
  sequence stalled;
    rx_valid_o && !rx_ready_i;
  endsequence
  sequence quiet_link;
    !sync_n_i && $stable(sync_n_i) && $stable(sclk_i);
  endsequence
  chk_sdo_idle: assert property (sync_n_i |-> !sdo_o)
    else $error("sdo not low between frames");
  chk_sdo_hold: assert property (quiet_link |-> $stable(sdo_o))
    else $error("sdo moved without a clock edge");
  chk_sdo_msb: assert property (frame_fall |-> sdo_o == pend_r[15])
    else $error("sdo lacks msb at frame start");
  chk_word_held: assert property (stalled |=> rx_valid_o && $stable(rx_word_o))
    else $error("held word lost");
  chk_ovr_sticky: assert property (rx_overrun_o |=> rx_overrun_o)
    else $error("overrun flag cleared");
  chk_ovr_cause: assert property ($rose(rx_overrun_o) |-> $past(rx_valid_o))
    else $error("overrun with empty buffer");
  chk_busy_set: assert property ((conv_busy_i && busy_en_i)[*2] |-> ##3 busy_pin_o)
    else $error("busy pin late");
  chk_busy_off: assert property ((!busy_en_i)[*2] |-> ##3 !busy_pin_o)
    else $error("busy pin without option");
endmodule

// attach beside every port instance
bind cio_port cio_port_monitor i_mon (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
  .sclk_i(sclk_i), .sync_n_i(sync_n_i), .sdo_o(sdo_o), .rx_valid_o(rx_valid_o),
  .rx_ready_i(rx_ready_i), .rx_word_o(rx_word_o), .tx_load_i(tx_load_i),
  .tx_word_i(tx_word_i), .rx_overrun_o(rx_overrun_o), .busy_en_i(busy_en_i),
  .conv_busy_i(conv_busy_i), .busy_pin_o(busy_pin_o));

//--- tb/testbench.sv
`timescale 1ns/1ps

module testbench;
  logic clock_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic sclk_i, sync_n_i, sdi_i, sdo_o, rx_valid_o, busy_pin_o, rx_overrun_o;
  logic rx_ready_i = 1'b0, tx_load_i = 1'b0, busy_en_i = 1'b0, conv_busy_i = 1'b0;
  logic [15:0] pin_role_i = 16'h0000, got, a, b;
  cio_pkg::cio_word_t rx_word_o, tx_word_i = 16'h0000;
  cio_pkg::cio_pin_sel_t pin_sel_o;
  int num_errors = 0, checked = 0, seed = 32'h5964;
  // port under test and its host
  cio_port i_cio_port (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .sclk_i(sclk_i),
    .sync_n_i(sync_n_i), .sdi_i(sdi_i), .sdo_o(sdo_o), .rx_valid_o(rx_valid_o),
    .rx_ready_i(rx_ready_i), .rx_word_o(rx_word_o), .tx_load_i(tx_load_i),
    .tx_word_i(tx_word_i), .pin_role_i(pin_role_i), .busy_en_i(busy_en_i),
    .conv_busy_i(conv_busy_i), .pin_sel_o(pin_sel_o), .busy_pin_o(busy_pin_o),
    .rx_overrun_o(rx_overrun_o));
  cio_host_model i_host (.sclk_o(sclk_i), .sync_n_o(sync_n_i), .sdi_o(sdi_i), .sdo_i(sdo_o));
  // 50 MHz system clock
  initial
    forever #10 clock_i = ~clock_i;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    if (num_errors == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // role selects expected from the pin encoding; the busy option clears pin 7
  function automatic logic [31:0] exp_sel(input logic [15:0] r, input logic be);
    logic [31:0] s;
    s = 32'h00000000;
    for (int p = 0; p < 8; p++)
      if (!(be && p == 7))
        s[8 * (3 - r[2*p +: 2]) + p] = 1'b1;
    return s;
  endfunction
  // load the return word, run a frame at a random idle level
  task automatic send(input logic [15:0] v, input int n, input logic [15:0] ret);
    @(negedge clock_i) tx_load_i = 1'b1;
    tx_word_i = ret;
    @(negedge clock_i) tx_load_i = 1'b0;
    repeat (3) @(negedge clock_i);
    got = 16'($random(seed));
    i_host.xfer(v, n, got[0], got);
    if (n == 16)
      check(got, ret);
    repeat (6) @(negedge clock_i);
  endtask
  // wait for a word, compare, take it
  task automatic pop(input logic [15:0] v);
    for (int k = 0; k < 20 && rx_valid_o !== 1'b1; k++)
      @(negedge clock_i);
    check(rx_valid_o, 1'b1);
    check(rx_word_o, v);
    rx_ready_i = 1'b1;
    @(negedge clock_i) rx_ready_i = 1'b0;
    @(negedge clock_i);
  endtask
  // hang guard; the tests need about 25 us, the guard waits over ten times that
  initial
  begin
    #400000;
    num_errors++;
    report_and_stop();
  end
  initial
  begin
    repeat (10) @(negedge clock_i);
    sys_rst_i = 1'b0;
    repeat (3) @(negedge clock_i);
    check(sdo_o, 1'b0);
    // random words both ways, all-ones corner first
    for (int k = 0; k < 6; k++)
    begin
      a = (k == 0) ? 16'hffff : 16'($random(seed));
      b = (k == 1) ? 16'h8001 : 16'($random(seed));
      send(a, 16, b);
      pop(a);
    end
    // a short frame leaves no word
    send(16'h1234, 8, 16'h0000);
    check(rx_valid_o, 1'b0);
    check(rx_overrun_o, 1'b0);
    // stalled consumer: two words kept, third dropped
    a = 16'($random(seed));
    b = 16'($random(seed));
    send(a, 16, a);
    send(b, 16, b);
    send(16'h5a5a, 16, 16'h0f0f);
    check(rx_overrun_o, 1'b1);
    pop(a);
    pop(b);
    check(rx_valid_o, 1'b0);
    // mid-run reset is the only way to clear the sticky overrun flag
    @(negedge clock_i) sys_rst_i = 1'b1;
    repeat (2) @(negedge clock_i);
    sys_rst_i = 1'b0;
    repeat (3) @(negedge clock_i);
    check(rx_overrun_o, 1'b0);
    // each role on all pins, then random roles; busy option toggled
    for (int k = 0; k < 12; k++)
    begin
      pin_role_i = (k < 4) ? {8{k[1:0]}} : 16'($random(seed));
      busy_en_i = k[0];
      conv_busy_i = k[1];
      repeat (5) @(negedge clock_i);
      check(pin_sel_o, exp_sel(pin_role_i, busy_en_i));
      check(busy_pin_o, k[0] & k[1]);
    end
    report_and_stop();
  end
endmodule
